// ---- rtl/tbpd_decoder.sv ----
// ahb-lite register block decoding type b request and apdu parameter fields
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tbpd_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// - request family zero always answers, whatever family is stored.
// - family upper-only value answers when upper nibble matches stored one.
// - family lower-only value answers when lower nibble matches stored one.
// - family with both nibbles set answers only on exact byte match.
// - card id is the low four bytes of the stored system id.
// - wait exponent is an integer from zero to fourteen.
// - longest wait is 4096 carrier cycles times two to the exponent.
// - read and write take mode and start address from p1 and p2.
// - p1 top bit set rejects read or write.
// - p1 bit 6 clear is radio memory access, set is tunnel.
// - p1 bits 5:4: 00 plain, 10 private key, 11 family key.
// - p1 bits 5:4 equal 01 is reserved and answered with error.
// - address unit is one byte in both plain and encrypted modes.
// - encrypted start address not multiple of sixteen gives error.
// - plaintext data block is all payload.
// - encrypted block is 16-byte vector, payload, 16-byte code.
// - encrypted length not multiple of sixteen gives error.
// - select with expected parameters completes normally without file system.
// - parameter faults report status 6a 86.
// - length faults report status 67 00.
// - success reports status 90 00.
module tbpd_decoder
  import tbpd_pkg::*;
#(
  parameter int ADDR_LIMIT = 32768
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic reqb_answer,
  output logic cmd_done
);

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic ap_valid;
  logic ap_write;
  logic [11:0] ap_addr;
  logic next_ap_valid;
  logic next_ap_write;
  logic [11:0] next_ap_addr;

  always_comb begin
    next_ap_valid = 1'b0;
    next_ap_write = ap_write;
    next_ap_addr = ap_addr;
    if (hready) begin
      next_ap_valid = hsel && (htrans == `TBPD_HTRANS_NONSEQ);
      next_ap_write = hwrite;
      next_ap_addr = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic family_match(input logic [7:0] req, input logic [7:0] stored);
    if (req == 8'h00) begin
      family_match = 1'b1;
    end else if (req[3:0] == 4'h0) begin
      family_match = (req[7:4] == stored[7:4]);
    end else if (req[7:4] == 4'h0) begin
      family_match = (req[3:0] == stored[3:0]);
    end else begin
      family_match = (req == stored);
    end
  endfunction : family_match

  function automatic tbpd_cipher_t cipher_of(input logic [7:0] p1);
    case ({p1[`TBPD_P1_ENC_HI], p1[`TBPD_P1_ENC_LO]})
      2'b00: cipher_of = TBPD_PLAIN;
      2'b10: cipher_of = TBPD_ENC_PRIVATE;
      2'b11: cipher_of = TBPD_ENC_FAMILY;
      default: cipher_of = TBPD_RESERVED;
    endcase
  endfunction : cipher_of

  //////////////////////////////////////////////////////////////////////////////
  // command word helpers
  function automatic logic is_rw(input logic [7:0] ins);
    is_rw = (ins == `TBPD_INS_READ) || (ins == `TBPD_INS_WRITE);
  endfunction : is_rw

  function automatic logic is_encrypted(input tbpd_cipher_t ciph);
    is_encrypted = (ciph == TBPD_ENC_PRIVATE) || (ciph == TBPD_ENC_FAMILY);
  endfunction : is_encrypted

  //////////////////////////////////////////////////////////////////////////////
  // bus write strobe, valid in the data phase
  logic wr_en;
  logic [31:0] next_hrdata;

  assign wr_en = ap_valid && ap_write;

  //////////////////////////////////////////////////////////////////////////////
  // stored system area settings
  logic [7:0] family;
  logic [31:0] sysid_lo;
  logic [7:0] fwi_byte;
  logic [7:0] next_family;
  logic [31:0] next_sysid_lo;
  logic [7:0] next_fwi_byte;

  always_comb begin
    next_family = family;
    next_sysid_lo = sysid_lo;
    next_fwi_byte = fwi_byte;
    if (wr_en) begin
      case (ap_addr)
        `TBPD_OFS_FAMILY: next_family = hwdata[7:0];
        `TBPD_OFS_SYSID_LO: next_sysid_lo = hwdata;
        `TBPD_OFS_FWI: next_fwi_byte = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      family <= `TBPD_RST_FAMILY;
      sysid_lo <= `TBPD_RST_SYSID;
      fwi_byte <= `TBPD_RST_FWI;
    end else begin
      family <= next_family;
      sysid_lo <= next_sysid_lo;
      fwi_byte <= next_fwi_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request family filter
  logic next_reqb_answer;

  always_comb begin
    next_reqb_answer = reqb_answer;
    // the answer stands until the next request, so a family change alone does not move it
    if (wr_en && (ap_addr == `TBPD_OFS_REQB)) begin
      next_reqb_answer = family_match(hwdata[7:0], family);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reqb_answer <= 1'b0;
    end else begin
      reqb_answer <= next_reqb_answer;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // card identifier
  logic [31:0] card_id;
  logic [31:0] next_card_id;

  always_comb begin
    next_card_id = sysid_lo;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_id <= `TBPD_RST_SYSID;
    end else begin
      card_id <= next_card_id;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame waiting time
  // whole microseconds only; the base period is truncated, not rounded
  localparam logic [31:0] WAIT_BASE_US = (`TBPD_WAIT_BASE_FC * 32'd1000) / `TBPD_FC_KHZ;

  logic [3:0] frame_wait_exponent;
  logic fwi_bad;
  logic [31:0] wait_us;
  logic [31:0] wait_table [0:15];

  assign frame_wait_exponent = fwi_byte[`TBPD_FWI_MSB:`TBPD_FWI_LSB];
  assign fwi_bad = (frame_wait_exponent > `TBPD_FWI_MAX);

  for (genvar g = 0; g < 16; g++) begin : g_wait
    assign wait_table[g] = WAIT_BASE_US << g;
  end

  assign wait_us = wait_table[frame_wait_exponent];

  //////////////////////////////////////////////////////////////////////////////
  // command capture and decode sequencing
  tbpd_cmd_t cmd;
  tbpd_state_t state;
  logic cmd_wr;
  tbpd_cmd_t next_cmd;
  tbpd_state_t next_state;
  logic next_cmd_done;

  assign cmd_wr = wr_en && (ap_addr == `TBPD_OFS_CMD);

  always_comb begin
    next_cmd = cmd;
    next_state = state;
    next_cmd_done = 1'b0;
    case (state)
      TBPD_IDLE: ;
      TBPD_DECODE: next_state = TBPD_DONE;
      TBPD_DONE: begin
        next_cmd_done = 1'b1;
        next_state = TBPD_IDLE;
      end
      default: next_state = TBPD_IDLE;
    endcase
    // a new command always restarts the decode, so one still in decode is dropped without its done pulse
    if (cmd_wr) begin
      next_cmd = hwdata;
      next_state = TBPD_DECODE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= '0;
      state <= TBPD_IDLE;
      cmd_done <= 1'b0;
    end else begin
      cmd <= next_cmd;
      state <= next_state;
      cmd_done <= next_cmd_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // parameter field checks
  tbpd_cipher_t ciph;
  logic [14:0] start_addr;
  logic top_bad;
  logic mode_bad;
  logic addr_bad;
  logic range_bad;
  logic len_bad;
  logic param_bad;

  assign ciph = cipher_of(cmd.p1);
  // mode bits 6:4 are not part of the address
  assign start_addr = {3'b000, cmd.p1[3:0], cmd.p2};
  assign top_bad = cmd.p1[`TBPD_P1_TOP];
  assign mode_bad = (ciph == TBPD_RESERVED);
  assign addr_bad = is_encrypted(ciph) && (start_addr[3:0] != 4'h0);
  assign range_bad = (32'(start_addr) >= 32'(ADDR_LIMIT));
  assign len_bad = is_encrypted(ciph)
                   && ((cmd.len[3:0] != 4'h0) || (cmd.len < `TBPD_ENC_OVERHEAD));
  assign param_bad = top_bad || mode_bad || addr_bad || range_bad;

  //////////////////////////////////////////////////////////////////////////////
  // decode result
  tbpd_result_t result;
  logic [7:0] payload_len;
  tbpd_result_t next_result;
  logic [7:0] next_payload_len;

  always_comb begin
    next_result = result;
    next_payload_len = payload_len;
    if (state == TBPD_DECODE) begin
      next_result.tunnel = cmd.p1[`TBPD_P1_TUNNEL];
      next_result.cipher = ciph;
      next_result.addr = start_addr;
      next_result.accept = 1'b0;
      next_payload_len = cmd.len;
      if (is_encrypted(ciph)) begin
        next_payload_len = cmd.len - `TBPD_ENC_OVERHEAD;
      end
      if (cmd.ins == `TBPD_INS_SELECT) begin
        // nothing stands behind select; it only has to look normal to the reader
        next_result.sw = `TBPD_SW_OK;
        next_result.accept = 1'b1;
      end else if (is_rw(cmd.ins)) begin
        if (param_bad) begin
          next_result.sw = `TBPD_SW_PARAM;
        end else if (len_bad) begin
          next_result.sw = `TBPD_SW_LENGTH;
        end else begin
          next_result.sw = `TBPD_SW_OK;
          next_result.accept = 1'b1;
        end
      end else begin
        next_result.sw = `TBPD_SW_INS;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= '0;
      payload_len <= 8'h00;
    end else begin
      result <= next_result;
      payload_len <= next_payload_len;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // readback words
  logic [31:0] status_word;
  logic [31:0] split_word;

  assign status_word = {result.sw, result.accept, result.tunnel, result.cipher, 1'b0,
                        state != TBPD_IDLE, 10'h000};
  assign split_word = {1'b0, result.addr, 8'h00, payload_len};

  //////////////////////////////////////////////////////////////////////////////
  // read data, zero-wait slave, always okay
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_ap_valid && !next_ap_write) begin
      case (next_ap_addr)
        `TBPD_OFS_CTRL: next_hrdata = {30'h0, fwi_bad, reqb_answer};
        `TBPD_OFS_FAMILY: next_hrdata = {24'h0, family};
        `TBPD_OFS_SYSID_LO: next_hrdata = sysid_lo;
        `TBPD_OFS_FWI: next_hrdata = {24'h0, fwi_byte};
        `TBPD_OFS_CMD: next_hrdata = cmd;
        `TBPD_OFS_STATUS: next_hrdata = status_word;
        `TBPD_OFS_CARDID: next_hrdata = card_id;
        `TBPD_OFS_WAIT: next_hrdata = wait_us;
        `TBPD_OFS_SPLIT: next_hrdata = split_word;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : tbpd_decoder
`default_nettype wire

// ---- rtl/tbpd_params.svh ----
// constants for the type b parameter decoder
`ifndef TBPD_PARAMS_SVH
`define TBPD_PARAMS_SVH
`define TBPD_OFS_CTRL 12'h000
`define TBPD_OFS_FAMILY 12'h004
`define TBPD_OFS_SYSID_LO 12'h008
`define TBPD_OFS_REQB 12'h00c
`define TBPD_OFS_FWI 12'h010
`define TBPD_OFS_CMD 12'h014
`define TBPD_OFS_STATUS 12'h018
`define TBPD_OFS_CARDID 12'h01c
`define TBPD_OFS_WAIT 12'h020
`define TBPD_OFS_SPLIT 12'h024
`define TBPD_RST_FAMILY 8'h00
`define TBPD_RST_SYSID 32'h0000_0000
`define TBPD_RST_FWI 8'h00
`define TBPD_FWI_MAX 4'he
`define TBPD_FWI_MSB 7
`define TBPD_FWI_LSB 4
`define TBPD_P1_TOP 7
`define TBPD_P1_TUNNEL 6
`define TBPD_P1_ENC_HI 5
`define TBPD_P1_ENC_LO 4
`define TBPD_CMD_INS_LSB 24
`define TBPD_CMD_P1_LSB 16
`define TBPD_CMD_P2_LSB 8
`define TBPD_CMD_LEN_LSB 0
`define TBPD_INS_SELECT 8'ha4
`define TBPD_INS_READ 8'hb0
`define TBPD_INS_WRITE 8'hd6
`define TBPD_SW_OK 16'h9000
`define TBPD_SW_PARAM 16'h6a86
`define TBPD_SW_LENGTH 16'h6700
`define TBPD_SW_INS 16'h6d00
`define TBPD_BLOCK_BYTES 8'h10
`define TBPD_ENC_OVERHEAD 8'h20
`define TBPD_WAIT_BASE_FC 32'd4096
`define TBPD_FC_KHZ 32'd13560
`define TBPD_HTRANS_NONSEQ 2'b10
`endif

// ---- rtl/tbpd_pkg.sv ----
// types for the type b parameter decoder
package tbpd_pkg;
  typedef enum logic [1:0] {
    TBPD_PLAIN,
    TBPD_ENC_PRIVATE,
    TBPD_ENC_FAMILY,
    TBPD_RESERVED
  } tbpd_cipher_t;
  typedef struct packed {
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] len;
  } tbpd_cmd_t;
  typedef struct packed {
    logic tunnel;
    tbpd_cipher_t cipher;
    logic accept;
    logic [15:0] sw;
    logic [14:0] addr;
  } tbpd_result_t;
  typedef enum logic [1:0] {
    TBPD_IDLE,
    TBPD_DECODE,
    TBPD_DONE
  } tbpd_state_t;
endpackage : tbpd_pkg

// ---- test/tbpd_monitor.sv ----
// port checker for the type b parameter decoder
`timescale 1ns/1ps
`default_nettype none
module tbpd_monitor
  import tbpd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reqb_answer,
  input wire logic cmd_done
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic tk = hsel && hready && htrans == 2'b10;
  wire logic st_rd = tk && !hwrite && haddr == 12'h018;
  logic cmd_d;
  logic reqb_d;
  tbpd_cmd_t lc;
  wire logic rw = lc.ins == 8'hb0 || lc.ins == 8'hd6;
  // command word lands in the data phase after its address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_d <= 1'b0;
      reqb_d <= 1'b0;
      lc <= '0;
    end else begin
      cmd_d <= tk && hwrite && haddr == 12'h014;
      reqb_d <= tk && hwrite && haddr == 12'h00c;
      if (cmd_d) lc <= hwdata;
    end
  end
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or error");
  property p_lat; tk && hwrite && haddr == 12'h014 |-> ##4 cmd_done; endproperty
  a_lat: assert property (p_lat) else $error("decode latency");
  property p_pulse; cmd_done |=> !cmd_done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_hold; !$stable(reqb_answer) |-> $past(reqb_d) || $past(reqb_d, 2); endproperty
  a_hold: assert property (p_hold) else $error("answer moved");
  property p_unmap; tk && !hwrite && haddr >= 12'h028 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_top; st_rd && rw && lc.p1[7] |=> hrdata[31:16] == 16'h6a86; endproperty
  a_top: assert property (p_top) else $error("top bit");
  property p_rsv; st_rd && rw && lc.p1[5:4] == 2'b01 |=> hrdata[31:16] == 16'h6a86; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mode");
  property p_sel; st_rd && lc.ins == 8'ha4 |=> hrdata[31:16] == 16'h9000; endproperty
  a_sel: assert property (p_sel) else $error("select");
  c_done: cover property (cmd_done);
  c_ans: cover property ($rose(reqb_answer));
  c_ok: cover property (st_rd ##1 hrdata[15]);
endmodule : tbpd_monitor
bind tbpd_decoder tbpd_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .reqb_answer, .cmd_done);
`default_nettype wire

// ---- test/tbpd_reader_model.sv ----
// reader model forming command words
`timescale 1ns/1ps
`default_nettype none
module tbpd_reader_model
  import tbpd_pkg::*;
(
  input wire logic [31:0] rnd,
  input wire logic [1:0] kind,
  output var tbpd_cmd_t cmd
);
  logic [1:0] md;
  // kinds 1 to 3 break the rules only on request
  always_comb begin
    md = (rnd[21:20] == 2'b01) ? 2'b00 : rnd[21:20];
    cmd.ins = rnd[0] ? 8'hd6 : 8'hb0;
    cmd.p1 = {1'b0, rnd[22], md, rnd[19:16]};
    cmd.p2 = md[1] ? {rnd[15:12], 4'h0} : rnd[15:8];
    cmd.len = md[1] ? {rnd[3:1], 4'h0} + 8'h20 : rnd[7:0];
    if (kind == 2'd1) cmd.p1[7] = 1'b1;
    if (kind == 2'd2) cmd.ins = rnd[8] ? 8'ha4 : rnd[31:24];
    if (kind == 2'd3) cmd = {cmd.ins, rnd[23:0]};
  end
endmodule : tbpd_reader_model
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the type b parameter decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tbpd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic reqb_answer;
  logic cmd_done;
  logic [31:0] seed = 32'haf38;
  logic [31:0] rnd = 32'h0;
  logic [1:0] kind = 2'd0;
  logic [31:0] r;
  logic [7:0] st;
  logic [7:0] q;
  logic ok;
  tbpd_cmd_t cmd;
  int n_mismatch = 0;
  int cmp_count = 0;
  tbpd_decoder dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .reqb_answer, .cmd_done);
  tbpd_reader_model rdr (.rnd, .kind, .cmd);
  initial forever #20 hclk = ~hclk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] exp_sw(input tbpd_cmd_t c);
    if (c.ins == 8'ha4) return 16'h9000;
    if (c.ins != 8'hb0 && c.ins != 8'hd6) return 16'h6d00;
    if (c.p1[7] || c.p1[5:4] == 2'b01) return 16'h6a86;
    if (c.p1[5] && c.p2[3:0] != 4'h0) return 16'h6a86;
    if (c.p1[5] && (c.len < 8'h20 || c.len[3:0] != 4'h0)) return 16'h6700;
    return 16'h9000;
  endfunction : exp_sw
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge hclk);
    chk(hrdata | {30'h0, reqb_answer, cmd_done}, 32'h0);
    hresetn <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      st = (i < 4) ? 8'h35 : seed[15:8];
      // mask walks zero, upper-only, lower-only and full request forms
      q = (seed[17] ? st : seed[7:0]) & {{4{i[0]}}, {4{i[1]}}};
      xfer(1'b1, 12'h004, {24'h0, st});
      xfer(1'b1, 12'h00c, {24'h0, q});
      repeat (2) @(posedge hclk);
      ok = (q == 8'h00) || (q[3:0] == 4'h0 ? q[7:4] == st[7:4] :
        q[7:4] == 4'h0 ? q[3:0] == st[3:0] : q == st);
      chk({31'h0, reqb_answer}, {31'h0, ok});
    end
    xfer(1'b1, 12'h008, seed);
    xfer(1'b0, 12'h01c, 32'h0);
    chk(r, seed);
    $display("family and id test done");
    for (int f = 0; f < 16; f++) begin
      seed = lfsr(seed);
      xfer(1'b1, 12'h010, {24'h0, f[3:0], seed[3:0]});
      xfer(1'b0, 12'h020, 32'h0);
      if (f < 15) chk(r, 32'd302 << f);
      xfer(1'b0, 12'h000, 32'h0);
      chk({31'h0, r[1]}, {31'h0, f == 15});
    end
    $display("wait test done");
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      rnd = seed;
      kind = i[1:0];
      #1;
      xfer(1'b1, 12'h014, cmd);
      ok = 1'b0;
      repeat (8) if (!ok) begin
        @(posedge hclk);
        ok = (cmd_done === 1'b1);
      end
      chk({31'h0, ok}, 32'h1);
      xfer(1'b0, 12'h018, 32'h0);
      chk({16'h0, r[31:16]}, {16'h0, exp_sw(cmd)});
      if (exp_sw(cmd) == 16'h9000 && cmd.ins != 8'ha4) begin
        chk({29'h0, r[14:12]}, {29'h0, cmd.p1[6], &cmd.p1[5:4], cmd.p1[5] & ~cmd.p1[4]});
        xfer(1'b0, 12'h024, 32'h0);
        chk({24'h0, r[7:0]}, {24'h0, cmd.len - (cmd.p1[5] ? 8'h20 : 8'h00)});
        chk({17'h0, r[30:16]}, {17'h0, 3'b000, cmd.p1[3:0], cmd.p2});
      end
    end
    $display("command test done");
    xfer(1'b1, 12'h100, seed);
    xfer(1'b0, 12'h100, 32'h0);
    chk(r, 32'h0);
    $display("unmapped test done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
